/* common/tscr_defs.svh */
// Offsets, field positions, reset values and masks of the tile status registers
`ifndef TSCR_DEFS_SVH
`define TSCR_DEFS_SVH

// ====
// Register numbers on the processor-status port
`define TSCR_ADDR_TILE_CONTROL      8'h02
`define TSCR_ADDR_TILE_BOOT_STATUS  8'h03
`define TSCR_ADDR_SECURITY_CONFIG   8'h05
`define TSCR_ADDR_RING_OSC_CONTROL  8'h06
`define TSCR_ADDR_RING_OSC_VALUE0   8'h07
`define TSCR_ADDR_RING_OSC_VALUE1   8'h08
`define TSCR_ADDR_RING_OSC_VALUE2   8'h09
`define TSCR_ADDR_RING_OSC_VALUE3   8'h0A

// ====
// Tile control fields
`define TSCR_TC_TXD_DELAY_HI        25
`define TSCR_TC_TXD_DELAY_LO        18
`define TSCR_TC_TXCLK_DIV_HI        17
`define TSCR_TC_TXCLK_DIV_LO        9
`define TSCR_TC_RGMII_EN_BIT        8
`define TSCR_TC_DIV_DYNAMIC_BIT     5
`define TSCR_TC_DIV_EN_BIT          4
`define TSCR_TC_UTMI_SEL_BIT        2
`define TSCR_TC_ULPI_EN_BIT         1
`define TSCR_TC_WRITE_MASK          32'h03FF_FF36
`define TSCR_TC_RESET               32'h0000_0000

// ====
// Boot status fields
`define TSCR_BS_PROC_NUM_LO         16
`define TSCR_BS_STRAP_OVR_BIT       8
`define TSCR_BS_CORE1_OFF_BIT       5
`define TSCR_BS_NO_OTP_POLL_BIT     4
`define TSCR_BS_BOOT_RAM_BIT        3
`define TSCR_BS_BOOT_JTAG_BIT       2
`define TSCR_BS_PLL_MODE_LO         0

// ====
// Security configuration fields
`define TSCR_SC_WRITE_LOCK_BIT      31
`define TSCR_SC_GLOBAL_DBG_DIS_BIT  14
`define TSCR_SC_OTP_LOCK_ALL_BIT    12
`define TSCR_SC_OTP_SECT_LOCK_HI    11
`define TSCR_SC_OTP_SECT_LOCK_LO    8
`define TSCR_SC_OTP_REDUND_BIT      7
`define TSCR_SC_OTP_BOOT_BIT        5
`define TSCR_SC_JTAG_CFG_PROT_BIT   4
`define TSCR_SC_JTAG_TAP_DIS_BIT    0
`define TSCR_SC_WRITE_MASK          32'h8000_5FB1
`define TSCR_SC_RESET               32'h0000_0000

// ====
// Ring oscillator control fields
`define TSCR_RO_PERIPH_EN_BIT       0
`define TSCR_RO_CORE_EN_BIT         1
`define TSCR_RO_WRITE_MASK          32'h0000_0003
`define TSCR_RO_RESET               32'h0000_0000
`define TSCR_RO_COUNT_INIT          16'h0000

// ====
// Minimum stop time before a counter read, in core clock cycles
`define TSCR_RO_SETTLE_CYCLES       10

`endif

/* common/tscr_pkg.sv */
// Types shared by the tile status register bank
package tscr_pkg;

    // Transmit data beat carried through the delay line
    typedef struct packed {
        logic [3:0] txd;
        logic       tx_ctl;
    } tscr_tx_beat_t;

    // Security controls driven out to the debug and OTP logic
    typedef struct packed {
        logic       global_dbg_dis;
        logic       otp_lock_all;
        logic [3:0] otp_sector_lock;
        logic       otp_redundancy_en;
        logic       otp_boot_override;
        logic       jtag_cfg_protect;
        logic       jtag_tap_dis;
    } tscr_sec_ctrl_t;

    // Tile mode controls driven out to the clock and USB logic
    typedef struct packed {
        logic rgmii_port_en;
        logic clk_div_active;
        logic utmi_sel;
        logic ulpi_en;
    } tscr_tile_ctrl_t;

    // Boot strap values presented during reset
    typedef struct packed {
        logic [7:0] proc_num;
        logic       strap_override;
        logic       core1_off;
        logic       no_otp_poll;
        logic       boot_ram;
        logic       boot_jtag;
        logic [1:0] pll_mode;
    } tscr_boot_straps_t;

endpackage : tscr_pkg

/* design/tscr_regs.sv */
// Tile processor-status register bank: control, boot status, security, ring oscillators
// Contract
// - Eight-bit transmit data delay in PLL cycles, reset zero.
// - Transmit clock rises at divider field value, falls at half of it.
// - Enable bit, reset zero, connects RGMII to its ports.
// - Dynamic bit: divide only while all threads paused; else always.
// - Divider enable bit, reset zero, divides the tile clock.
// - USB mode bit: one selects UTMI, zero ULPI.
// - ULPI enable bit activates the ULPI support logic.
// - Boot status is read-only: processor number, PLL mode pins.
// - Boot status flags core-one off, boot from RAM, boot from JTAG.
// - Boot status flags strap override and skipped OTP level polling.
// - Security top bit set blocks further writes to that register.
// - Global debug disable bit blocks the global debug facility.
// - Lock-all OTP bit and four per-sector OTP lock bits.
// - OTP boot override bit loads the boot image from OTP.
// - Configuration protection bit denies JTAG access to PLL and boot registers.
// - Security bit zero denies access to the JTAG debug port.
// - Security register loads from the OTP security word.
// - Four oscillators each clock a counter, started by two enables.
// - Counter values serve as random bits.
// - Counters are 16 bits, readable, kept over reset.
`timescale 1ns/1ps
`default_nettype none
`include "tscr_defs.svh"

module tscr_regs (
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    // Processor-status access port
    input  wire logic                       ps_wr,
    input  wire logic                       ps_rd,
    input  wire logic [7:0]                 ps_addr,
    input  wire logic [31:0]                ps_wdata,
    output var  logic [31:0]                ps_rdata,
    output var  logic                       ps_ack,
    // Boot straps and OTP security word
    input  wire tscr_pkg::tscr_boot_straps_t boot_straps,
    input  wire logic                       otp_sec_load,
    input  wire logic [31:0]                otp_sec_word,
    // Thread activity
    input  wire logic                       all_threads_paused,
    // RGMII transmit path
    input  wire tscr_pkg::tscr_tx_beat_t    tx_beat_in,
    output var  tscr_pkg::tscr_tx_beat_t    tx_beat_out,
    output var  logic                       rgmii_tx_clk,
    // Mode and security controls
    output var  tscr_pkg::tscr_tile_ctrl_t  tile_ctrl,
    output var  tscr_pkg::tscr_sec_ctrl_t   sec_ctrl,
    // Ring oscillators
    input  wire logic [3:0]                 osc_tick,
    output var  logic [1:0]                 osc_run
);

    // ====
    // Register state
    logic [31:0] tile_control_reg;
    logic [31:0] tile_control_next;
    logic [31:0] tile_boot_status_reg;
    logic [31:0] tile_boot_status_next;
    logic [31:0] security_configuration_reg;
    logic [31:0] security_configuration_next;
    logic [31:0] ring_oscillator_control_reg;
    logic [31:0] ring_oscillator_control_next;
    logic [31:0] ps_rdata_reg;
    logic [31:0] ps_rdata_next;
    logic        ps_ack_reg;
    logic        ps_ack_next;
    logic [15:0] osc_count [4];
    logic [3:0]  osc_en;

    // ====
    // Field views of tile control
    logic [7:0]  txd_delay;
    logic [8:0]  txclk_div;
    logic        rgmii_en;
    logic        div_dynamic;
    logic        div_en;

    assign txd_delay   = tile_control_reg[`TSCR_TC_TXD_DELAY_HI:`TSCR_TC_TXD_DELAY_LO];
    assign txclk_div   = tile_control_reg[`TSCR_TC_TXCLK_DIV_HI:`TSCR_TC_TXCLK_DIV_LO];
    assign rgmii_en    = tile_control_reg[`TSCR_TC_RGMII_EN_BIT];
    assign div_dynamic = tile_control_reg[`TSCR_TC_DIV_DYNAMIC_BIT];
    assign div_en      = tile_control_reg[`TSCR_TC_DIV_EN_BIT];

    // ====
    // Register writes, OTP load and strap capture
    always_comb begin
        tile_control_next            = tile_control_reg;
        tile_boot_status_next        = tile_boot_status_reg;
        security_configuration_next  = security_configuration_reg;
        ring_oscillator_control_next = ring_oscillator_control_reg;

        // Straps are followed while reset is held, then frozen
        if (sys_rst) begin
            tile_boot_status_next = 32'h0000_0000;
            tile_boot_status_next[23:`TSCR_BS_PROC_NUM_LO]   = boot_straps.proc_num;
            tile_boot_status_next[`TSCR_BS_PLL_MODE_LO +: 2] = boot_straps.pll_mode;
            tile_boot_status_next[`TSCR_BS_CORE1_OFF_BIT]    = boot_straps.core1_off;
            tile_boot_status_next[`TSCR_BS_BOOT_RAM_BIT]     = boot_straps.boot_ram;
            tile_boot_status_next[`TSCR_BS_BOOT_JTAG_BIT]    = boot_straps.boot_jtag;
            tile_boot_status_next[`TSCR_BS_STRAP_OVR_BIT]    = boot_straps.strap_override;
            tile_boot_status_next[`TSCR_BS_NO_OTP_POLL_BIT]  = boot_straps.no_otp_poll;
        end

        // Software writes, reserved bits masked off
        if (ps_wr) begin
            unique case (ps_addr)
                `TSCR_ADDR_TILE_CONTROL: begin
                    tile_control_next = ps_wdata & `TSCR_TC_WRITE_MASK;
                end
                `TSCR_ADDR_SECURITY_CONFIG: begin
                    if (!security_configuration_reg[`TSCR_SC_WRITE_LOCK_BIT]) begin
                        security_configuration_next = ps_wdata & `TSCR_SC_WRITE_MASK;
                    end
                end
                `TSCR_ADDR_RING_OSC_CONTROL: begin
                    ring_oscillator_control_next = ps_wdata & `TSCR_RO_WRITE_MASK;
                end
                default: begin
                    // Boot status, counters and unmapped numbers ignore writes
                end
            endcase
        end

        // OTP security word wins over a software write in the same cycle
        if (otp_sec_load) begin
            security_configuration_next = otp_sec_word & `TSCR_SC_WRITE_MASK;
        end
    end

    // Register stage for the bank
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tile_control_reg            <= `TSCR_TC_RESET;
            security_configuration_reg  <= `TSCR_SC_RESET;
            ring_oscillator_control_reg <= `TSCR_RO_RESET;
        end else begin
            tile_control_reg            <= tile_control_next;
            security_configuration_reg  <= security_configuration_next;
            ring_oscillator_control_reg <= ring_oscillator_control_next;
        end
        tile_boot_status_reg <= tile_boot_status_next;
    end

    // ====
    // Read path, one cycle from request to data
    always_comb begin
        ps_rdata_next = ps_rdata_reg;
        ps_ack_next   = ps_wr | ps_rd;
        if (ps_rd) begin
            unique case (ps_addr)
                `TSCR_ADDR_TILE_CONTROL:     ps_rdata_next = tile_control_reg;
                `TSCR_ADDR_TILE_BOOT_STATUS: ps_rdata_next = tile_boot_status_reg;
                `TSCR_ADDR_SECURITY_CONFIG:  ps_rdata_next = security_configuration_reg;
                `TSCR_ADDR_RING_OSC_CONTROL: ps_rdata_next = ring_oscillator_control_reg;
                `TSCR_ADDR_RING_OSC_VALUE0:  ps_rdata_next = {16'h0000, osc_count[0]};
                `TSCR_ADDR_RING_OSC_VALUE1:  ps_rdata_next = {16'h0000, osc_count[1]};
                `TSCR_ADDR_RING_OSC_VALUE2:  ps_rdata_next = {16'h0000, osc_count[2]};
                `TSCR_ADDR_RING_OSC_VALUE3:  ps_rdata_next = {16'h0000, osc_count[3]};
                default:                     ps_rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ps_rdata_reg <= 32'h0000_0000;
            ps_ack_reg   <= 1'b0;
        end else begin
            ps_rdata_reg <= ps_rdata_next;
            ps_ack_reg   <= ps_ack_next;
        end
    end

    assign ps_rdata = ps_rdata_reg;
    assign ps_ack   = ps_ack_reg;

    // ====
    // Transmit clock divider
    logic [8:0] txclk_cnt_reg;
    logic [8:0] txclk_cnt_next;
    logic       txclk_reg;
    logic       txclk_next;

    // Counter wraps at the field value, ratio is field plus one
    always_comb begin
        txclk_cnt_next = txclk_cnt_reg + 9'h001;
        txclk_next     = txclk_reg;
        if (txclk_cnt_reg >= txclk_div) begin
            txclk_cnt_next = 9'h000;
        end
        if (txclk_cnt_reg == (txclk_div >> 1)) begin
            txclk_next = 1'b0;
        end
        if (txclk_cnt_reg == txclk_div) begin
            txclk_next = 1'b1;
        end
        if (!rgmii_en) begin
            txclk_next = 1'b0;
        end
    end

    // Divider state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txclk_cnt_reg <= 9'h000;
            txclk_reg     <= 1'b0;
        end else begin
            txclk_cnt_reg <= txclk_cnt_next;
            txclk_reg     <= txclk_next;
        end
    end

    assign rgmii_tx_clk = txclk_reg;

    // ====
    // Transmit data delay line, 256 entries
    tscr_pkg::tscr_tx_beat_t delay_mem [256];
    tscr_pkg::tscr_tx_beat_t tx_out_reg;
    tscr_pkg::tscr_tx_beat_t tx_out_next;
    logic [7:0]              wr_ptr_reg;
    logic [7:0]              wr_ptr_next;
    logic [7:0]              rd_ptr;

    // Entry at write pointer minus delay was written that many cycles ago
    always_comb begin
        rd_ptr      = wr_ptr_reg - txd_delay;
        wr_ptr_next = wr_ptr_reg + 8'h01;
        tx_out_next = delay_mem[rd_ptr];
        if (txd_delay == 8'h00) begin
            tx_out_next = tx_beat_in;
        end
        if (!rgmii_en) begin
            tx_out_next = '0;
        end
    end

    // Delay storage holds data only, no reset needed
    always_ff @(posedge clk_sys) begin
        delay_mem[wr_ptr_reg] <= tx_beat_in;
        if (sys_rst) begin
            wr_ptr_reg <= 8'h00;
            tx_out_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            tx_out_reg <= tx_out_next;
        end
    end

    assign tx_beat_out = tx_out_reg;

    // ====
    // Mode and security control outputs
    tscr_pkg::tscr_tile_ctrl_t tile_ctrl_reg;
    tscr_pkg::tscr_tile_ctrl_t tile_ctrl_next;
    tscr_pkg::tscr_sec_ctrl_t  sec_ctrl_reg;
    tscr_pkg::tscr_sec_ctrl_t  sec_ctrl_next;
    logic [1:0]                osc_run_reg;
    logic [1:0]                osc_run_next;

    // Decode fields into the controls they steer
    always_comb begin
        tile_ctrl_next.rgmii_port_en  = rgmii_en;
        tile_ctrl_next.clk_div_active = div_en && (!div_dynamic || all_threads_paused);
        tile_ctrl_next.utmi_sel       = tile_control_reg[`TSCR_TC_UTMI_SEL_BIT];
        tile_ctrl_next.ulpi_en        = tile_control_reg[`TSCR_TC_ULPI_EN_BIT];

        sec_ctrl_next.global_dbg_dis    = security_configuration_reg[`TSCR_SC_GLOBAL_DBG_DIS_BIT];
        sec_ctrl_next.otp_lock_all      = security_configuration_reg[`TSCR_SC_OTP_LOCK_ALL_BIT];
        sec_ctrl_next.otp_sector_lock   =
            security_configuration_reg[`TSCR_SC_OTP_SECT_LOCK_HI:`TSCR_SC_OTP_SECT_LOCK_LO];
        sec_ctrl_next.otp_redundancy_en = security_configuration_reg[`TSCR_SC_OTP_REDUND_BIT];
        sec_ctrl_next.otp_boot_override = security_configuration_reg[`TSCR_SC_OTP_BOOT_BIT];
        sec_ctrl_next.jtag_cfg_protect  = security_configuration_reg[`TSCR_SC_JTAG_CFG_PROT_BIT];
        sec_ctrl_next.jtag_tap_dis      = security_configuration_reg[`TSCR_SC_JTAG_TAP_DIS_BIT];

        osc_run_next[1] = ring_oscillator_control_reg[`TSCR_RO_CORE_EN_BIT];
        osc_run_next[0] = ring_oscillator_control_reg[`TSCR_RO_PERIPH_EN_BIT];
    end

    // Output flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tile_ctrl_reg <= '0;
            sec_ctrl_reg  <= '0;
            osc_run_reg   <= 2'h0;
        end else begin
            tile_ctrl_reg <= tile_ctrl_next;
            sec_ctrl_reg  <= sec_ctrl_next;
            osc_run_reg   <= osc_run_next;
        end
    end

    assign tile_ctrl = tile_ctrl_reg;
    assign sec_ctrl  = sec_ctrl_reg;
    assign osc_run   = osc_run_reg;

    // ====
    // Ring oscillator counters: two core cells, two peripheral cells
    assign osc_en = {osc_run_reg[0], osc_run_reg[0], osc_run_reg[1], osc_run_reg[1]};

    // One counter per oscillator
    for (genvar i = 0; i < 4; i++) begin : g_ring
        tscr_ring_counter u_ring (
            .clk_sys  (clk_sys),
            .run      (osc_en[i]),
            .osc_tick (osc_tick[i]),
            .count    (osc_count[i])
        );
    end

endmodule : tscr_regs

`default_nettype wire

/* design/tscr_ring_counter.sv */
// Sixteen-bit counter advanced by one ring oscillator
`timescale 1ns/1ps
`default_nettype none
`include "tscr_defs.svh"

module tscr_ring_counter (
    input  wire logic        clk_sys,
    input  wire logic        run,
    input  wire logic        osc_tick,
    output var  logic [15:0] count
);

    logic [15:0] count_reg = `TSCR_RO_COUNT_INIT; // Power-on value only
    logic [15:0] count_next;

    // ====
    // Counter, deliberately without reset
    always_comb begin
        count_next = count_reg;
        if (run && osc_tick) begin
            count_next = count_reg + 16'h0001;
        end
    end

    // Value survives system reset
    always_ff @(posedge clk_sys) begin
        count_reg <= count_next;
    end

    assign count = count_reg;

endmodule : tscr_ring_counter

`default_nettype wire

/* testbench/test_tile_status_control_regs.sv */
// Self-checking bench for the tile status register bank
`timescale 1ns/1ps
`default_nettype none

module test_tile_status_control_regs;
    logic                        clk_sys = 1'b0;
    logic                        sys_rst = 1'b1;
    logic                        ps_wr = 1'b0, ps_rd = 1'b0, otp_sec_load = 1'b0, all_threads_paused = 1'b0;
    logic                        ps_ack, rgmii_tx_clk, rd_seen = 1'b0, pv;
    logic [7:0]                  ps_addr = 8'h00, dl;
    logic [8:0]                  dv;
    logic [31:0]                 ps_wdata = 32'h0, otp_sec_word = 32'h0, ps_rdata, v, r;
    logic [3:0]                  osc_tick = 4'h0;
    logic [1:0]                  osc_run;
    logic [63:0]                 e;
    logic [63:0]                 exp_q[$];
    logic [15:0]                 base[4];
    tscr_pkg::tscr_boot_straps_t boot_straps = 15'h0;
    tscr_pkg::tscr_tx_beat_t     tx_beat_in = 5'h00, tx_beat_out;
    tscr_pkg::tscr_tx_beat_t     hist[100];
    tscr_pkg::tscr_tile_ctrl_t   tile_ctrl;
    tscr_pkg::tscr_sec_ctrl_t    sec_ctrl;
    int                          err_count = 0, cmp_count = 0, last, hi, n[4];
    localparam logic [31:0]      ALL = 32'hFFFF_FFFF;
    localparam logic [31:0]      TBL[4] = '{32'h0000_0130, 32'h0000_0130, 32'h0000_0010, 32'hFFFF_FFFF};

    tscr_regs u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_addr(ps_addr), .ps_wdata(ps_wdata),
        .ps_rdata(ps_rdata), .ps_ack(ps_ack), .boot_straps(boot_straps), .otp_sec_load(otp_sec_load),
        .otp_sec_word(otp_sec_word), .all_threads_paused(all_threads_paused), .tx_beat_in(tx_beat_in),
        .tx_beat_out(tx_beat_out), .rgmii_tx_clk(rgmii_tx_clk), .tile_ctrl(tile_ctrl), .sec_ctrl(sec_ctrl),
        .osc_tick(osc_tick), .osc_run(osc_run)
    );

    // ====
    // Clock, watchdog and read-result monitor
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_count++;
        summarize();
    end
    always @(posedge clk_sys) rd_seen <= ps_rd;
    always @(negedge clk_sys) begin
        if (ps_ack === 1'b1 && rd_seen) begin
            e = exp_q.pop_front();
            chk("ps_rdata", e[31:0], ps_rdata & e[63:32]);
        end
    end

    // ====
    // Compare, bus and closing tasks
    task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, ex, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        ps_wr = 1'b1;
        ps_addr = a;
        ps_wdata = d;
        @(negedge clk_sys);
        ps_wr = 1'b0;
        chk("ps_ack", 32'h1, {31'h0, ps_ack});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        @(negedge clk_sys);
        ps_rd = 1'b1;
        ps_addr = a;
        exp_q.push_back({m, x & m});
        @(negedge clk_sys);
        ps_rd = 1'b0;
        @(negedge clk_sys);
    endtask : rd
    task automatic otp(input logic [31:0] w);
        @(negedge clk_sys);
        otp_sec_load = 1'b1;
        otp_sec_word = w;
        @(negedge clk_sys);
        otp_sec_load = 1'b0;
    endtask : otp
    task automatic tcw(input logic [31:0] d);
        wr(8'h02, d);
        @(negedge clk_sys);
        chk("tile_ctrl", {28'h0, d[8], d[4] & (!d[5] | all_threads_paused), d[2], d[1]}, {28'h0, tile_ctrl});
        rd(8'h02, d, 32'h03FF_FF36);
    endtask : tcw
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // ====
    // Main sequence
    initial begin
        void'($urandom(32'h3255));
        r = $urandom;
        boot_straps = r[14:0];
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        // Reset values, read-only boot status, unmapped place
        v = {8'h00, boot_straps.proc_num, 7'h00, boot_straps.strap_override, 2'b00, boot_straps.core1_off,
             boot_straps.no_otp_poll, boot_straps.boot_ram, boot_straps.boot_jtag, boot_straps.pll_mode};
        rd(8'h02, 32'h0, ALL);
        rd(8'h06, 32'h0, ALL);
        r = $urandom;
        boot_straps = r[14:0];
        wr(8'h03, ALL);
        rd(8'h03, v, ALL);
        wr(8'h04, ALL);
        rd(8'h04, 32'h0, ALL);
        $display("boot status test done");
        // Tile control table and random words
        for (int k = 0; k < 12; k++) begin
            r = $urandom;
            all_threads_paused = (k < 4) ? k[0] : r[0];
            tcw((k < 4) ? TBL[k] : $urandom);
        end
        tcw(32'h0000_0030);
        @(negedge clk_sys);
        all_threads_paused = ~all_threads_paused;
        repeat (2) @(negedge clk_sys);
        chk("clk_div_active", {31'h0, all_threads_paused}, {31'h0, tile_ctrl.clk_div_active});
        $display("tile control test done");
        // Transmit delay and clock divider
        for (int k = 0; k < 2; k++) begin
            dl = k[0] ? 8'h07 : 8'h00;
            dv = k[0] ? 9'h008 : 9'h005;
            wr(8'h02, {6'h00, dl, dv, 9'h100});
            last = -1;
            hi = 0;
            pv = 1'b1;
            for (int j = 0; j < 100; j++) begin
                @(negedge clk_sys);
                if (j > 20) chk("tx_beat_out", 32'(hist[j - dl - 1]), 32'(tx_beat_out));
                if (rgmii_tx_clk === 1'b1 && !pv) begin
                    if (last >= 0) chk("tx_clk_period", 32'(dv) + 1, 32'(j - last));
                    if (last >= 0) chk("tx_clk_high", 32'(dv >> 1) + 1, 32'(hi));
                    last = j;
                    hi = 0;
                end
                hi += (rgmii_tx_clk === 1'b1);
                pv = rgmii_tx_clk;
                r = $urandom;
                hist[j] = r[4:0];
                tx_beat_in = hist[j];
            end
        end
        tcw(32'h0);
        $display("transmit path test done");
        // Security word load, write lock and override by reload
        r = $urandom & 32'h7FFF_FFFF;
        otp(r);
        rd(8'h05, r, 32'h8000_5FB1);
        v = $urandom | 32'h8000_0000;
        wr(8'h05, v);
        rd(8'h05, v, 32'h8000_5FB1);
        wr(8'h05, ~v);
        rd(8'h05, v, 32'h8000_5FB1);
        otp(r);
        rd(8'h05, r, 32'h8000_5FB1);
        wr(8'h05, ALL);
        rd(8'h05, ALL, 32'h8000_5FB1);
        chk("sec_ctrl", 32'h3FF, 32'(sec_ctrl));
        $display("security test done");
        // Oscillator counters per enable combination
        for (int i = 0; i < 4; i++) begin
            rd(8'h07 + 8'(i), 32'h0, ALL);
            base[i] = 16'h0000;
        end
        for (int m = 1; m < 4; m++) begin
            wr(8'h06, {30'h3FFF_FFFF, 2'(m)});
            rd(8'h06, 32'(m), ALL);
            chk("osc_run", 32'(m), 32'(osc_run));
            n = '{default: 0};
            repeat (3) @(negedge clk_sys);
            for (int j = 0; j < 30; j++) begin
                @(negedge clk_sys);
                r = $urandom;
                osc_tick = r[3:0];
                for (int i = 0; i < 4; i++) n[i] += r[i];
            end
            @(negedge clk_sys);
            osc_tick = 4'h0;
            wr(8'h06, 32'h0);
            repeat (10) @(negedge clk_sys);
            for (int i = 0; i < 4; i++) begin
                if (m[(i < 2) ? 1 : 0]) base[i] += 16'(n[i]);
                rd(8'h07 + 8'(i), {16'h0, base[i]}, ALL);
            end
        end
        // Counters survive a second reset, controls do not
        @(negedge clk_sys);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) rd(8'h07 + 8'(i), {16'h0, base[i]}, ALL);
        rd(8'h05, 32'h0, ALL);
        $display("oscillator test done");
        if (exp_q.size() != 0) err_count++;
        summarize();
    end
endmodule : test_tile_status_control_regs
`default_nettype wire

/* testbench/tscr_regs_chk.sv */
// Property checker for the tile status register bank
`timescale 1ns/1ps
`default_nettype none

module tscr_regs_chk (
    input wire logic                      clk_sys,
    input wire logic                      sys_rst,
    input wire logic                      ps_wr,
    input wire logic                      ps_rd,
    input wire logic [7:0]                ps_addr,
    input wire logic [31:0]               ps_wdata,
    input wire logic [31:0]               ps_rdata,
    input wire logic                      otp_sec_load,
    input wire logic [31:0]               otp_sec_word,
    input wire logic                      all_threads_paused,
    input wire tscr_pkg::tscr_tx_beat_t   tx_beat_out,
    input wire logic                      rgmii_tx_clk,
    input wire tscr_pkg::tscr_tile_ctrl_t tile_ctrl,
    input wire tscr_pkg::tscr_sec_ctrl_t  sec_ctrl
);
    // ====
    // Helpers
    wire logic tc_wr = ps_wr && ps_addr == 8'h02;

    function automatic tscr_pkg::tscr_sec_ctrl_t sec_of(input logic [31:0] w);
        return {w[14], w[12], w[11:8], w[7], w[5], w[4], w[0]};
    endfunction : sec_of

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ====
    // Tile control outputs follow a write two cycles on
    rgmii_en_a: assert property (tc_wr |=> ##1 tile_ctrl.rgmii_port_en == $past(ps_wdata[8], 2))
        else $error("rgmii enable does not follow tile control write");
    usb_mode_a: assert property (tc_wr |=> ##1 {tile_ctrl.utmi_sel, tile_ctrl.ulpi_en} == $past(ps_wdata[2:1], 2))
        else $error("usb mode outputs do not follow tile control write");
    div_static_a: assert property ((tc_wr && !ps_wdata[5]) |=> ##1 tile_ctrl.clk_div_active == $past(ps_wdata[4], 2))
        else $error("static divider enable wrong");
    div_dynamic_a: assert property ((tc_wr && ps_wdata[5:4] == 2'b11) ##1 1'b1
                                    |=> tile_ctrl.clk_div_active == $past(all_threads_paused))
        else $error("dynamic divider does not track paused threads");
    rgmii_off_a: assert property (!tile_ctrl.rgmii_port_en [*2] |-> !rgmii_tx_clk && tx_beat_out == 5'h00)
        else $error("rgmii outputs active while disabled");
    // Security outputs and reads
    otp_load_a: assert property (otp_sec_load |=> ##1 sec_ctrl == sec_of($past(otp_sec_word, 2)))
        else $error("security outputs differ from loaded word");
    rd_unmapped_a: assert property ((ps_rd && !(ps_addr inside {8'h02, 8'h03, [8'h05:8'h0A]})) |=> ps_rdata == 32'h0)
        else $error("unmapped read not zero");
    sec_write_a: assert property ((ps_wr && ps_addr == 8'h05 && !otp_sec_load)
                                  |=> ##1 (sec_ctrl == $past(sec_ctrl) || sec_ctrl == sec_of($past(ps_wdata, 2))))
        else $error("security outputs changed to an unwritten value");

    cover property (tc_wr && ps_wdata[5:4] == 2'b11 && ps_wdata[8]);
    cover property (otp_sec_load);
    cover property (ps_wr && ps_addr == 8'h06);
endmodule : tscr_regs_chk

bind tscr_regs tscr_regs_chk u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_addr(ps_addr), .ps_wdata(ps_wdata),
    .ps_rdata(ps_rdata), .otp_sec_load(otp_sec_load), .otp_sec_word(otp_sec_word),
    .all_threads_paused(all_threads_paused), .tx_beat_out(tx_beat_out), .rgmii_tx_clk(rgmii_tx_clk),
    .tile_ctrl(tile_ctrl), .sec_ctrl(sec_ctrl)
);
`default_nettype wire
